/* File: rtl/pic_cmd_map.vh */
`ifndef PIC_CMD_MAP_VH
`define PIC_CMD_MAP_VH

// Port select line values
`define PORT_SEL_COMMAND 1'b0
`define PORT_SEL_MASK 1'b1

// First initialization word fields
`define W1_FOURTH_NEEDED 0
`define W1_SINGLE 1
`define W1_INTERVAL 2
`define W1_LEVEL_TRIG 3
`define W1_MARK 4
`define W1_ADDR_LSB 5
`define W1_ADDR_MSB 7

// Fourth initialization word fields
`define W4_PROC_MODE 0
`define W4_AUTO_EOS 1
`define W4_ROLE 2
`define W4_BUFFERED 3
`define W4_SPECIAL_NEST 4

// Second and third operation word fields
`define OP_KIND 3
`define OP2_END 5
`define OP2_SELECT_LEVEL 6
`define OP2_ROTATE 7
`define OP3_READ_SEL 0
`define OP3_READ_REG 1
`define OP3_MASK_SEL 5
`define OP3_MASK_CHANGE 6

// Reset and default values
`define MASK_RESET 8'h00
`define SLAVE_ID_RESET 3'h7
`define DEFAULT_LEVEL 3'h7
`define CALL_OPCODE 8'hcd

// Acknowledge pulses per sequence
`define ACK_LAST_8BIT 2'h3
`define ACK_LAST_16BIT 2'h2

`endif

/* File: rtl/pin_sync.v */
module pin_sync #(
  parameter W = 1
) (
  input wire i_mclk, // System clock
  input wire i_nrst, // Asynchronous reset, active low
  input wire i_ce, // Clock enable
  input wire [W-1:0] i_async, // Asynchronous level inputs
  output reg [W-1:0] o_stable // Filtered level
);

reg [W-1:0] s1_reg;
reg [W-1:0] s2_reg;
reg [W-1:0] s3_reg;

// A bit moves only once the second and third stages agree on it
always @(posedge i_mclk or negedge i_nrst) begin
  if (!i_nrst) begin
    s1_reg <= {W{1'b0}};
    s2_reg <= {W{1'b0}};
    s3_reg <= {W{1'b0}};
    o_stable <= {W{1'b0}};
  end else if (i_ce) begin
    s1_reg <= i_async;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
    o_stable <= (s2_reg & s3_reg) | (o_stable & (s2_reg | s3_reg));
  end
end

endmodule // pin_sync

/* File: rtl/pic_cmd.v */
`include "pic_cmd_map.vh"

// Summary of operation
// - 16-bit vector: high bits plus level
// - Step through two to four init words
// - Command write with bit 4 restarts init
// - First word resets edges, mask, modes
// - No fourth word zeroes its functions
// - Interval bit picks 4 or 8 spacing
// - 8-bit address gets inserted low bits
// - Level trigger bypasses edge detection
// - Master drives slave identity on cascade
// - Slave answers when cascade matches identity
// - Buffered mode: pin enables, role bit
// - Mode bit picks 8 or 16-bit
// - Auto end-of-service at last acknowledge
// - Operation words accepted after init
// - Mask port write loads eight bits
// - Special mask mode enter, leave, keep
// - Input 0 highest, 7 lowest priority
// - In-service blocks equal and lower
// - Non-specific end clears highest in-service
// - Specific end clears the named level
// - No request answers as level 7
module pic_cmd (
  input wire i_mclk, // System clock, 40 MHz
  input wire i_nrst, // Asynchronous reset, active low
  input wire i_ce, // Clock enable, freezes all state when low
  input wire i_cs_n, // Chip select, active low
  input wire i_wr_n, // Write strobe, active low
  input wire i_rd_n, // Read strobe, active low
  input wire i_port_select_line, // Port select line
  input wire [7:0] i_data, // Data bus in
  output reg [7:0] o_data, // Data bus out
  output reg o_data_oe, // Data bus output enable
  input wire [7:0] i_request_inputs, // Request inputs
  input wire i_acknowledge_strobe_n, // Acknowledge strobe, active low
  output reg o_int, // Interrupt to host, active high
  input wire [2:0] i_cascade_lines, // Cascade lines in
  output reg [2:0] o_cascade_lines, // Cascade lines out
  output reg o_cascade_oe, // Cascade lines output enable
  input wire i_slave_program_or_buffer_enable, // Role strap when unbuffered
  output reg o_slave_program_or_buffer_enable, // Buffer enable, active low
  output reg o_slave_program_or_buffer_enable_oe // High in buffered mode
);

localparam ST_WAIT_W1 = 3'h0;
localparam ST_WAIT_W2 = 3'h1;
localparam ST_WAIT_W3 = 3'h2;
localparam ST_WAIT_W4 = 3'h3;
localparam ST_READY = 3'h4;

// Strobes are combined before the synchronisers so one filter covers each
wire [23:0] sync_in;
wire [23:0] sync_out;
wire wr_f;
wire rd_f;
wire ack_f;
wire sel_f;
wire sp_f;
wire [7:0] data_f;
wire [7:0] req_f;
wire [2:0] cas_f;

assign sync_in = {~i_cs_n & ~i_wr_n, ~i_cs_n & ~i_rd_n, ~i_acknowledge_strobe_n, i_port_select_line,
                  i_slave_program_or_buffer_enable, i_data, i_request_inputs, i_cascade_lines};
assign {wr_f, rd_f, ack_f, sel_f, sp_f, data_f, req_f, cas_f} = sync_out;

pin_sync #(.W(24)) u_sync (
  .i_mclk(i_mclk),
  .i_nrst(i_nrst),
  .i_ce(i_ce),
  .i_async(sync_in),
  .o_stable(sync_out)
);

reg [2:0] state_reg;
reg [2:0] state_next;
reg wr_d_reg;
reg rd_d_reg;
reg ack_d_reg;
reg [7:0] wdata_reg;
reg wsel_reg;
reg [7:0] mask_register;
reg [7:0] request_register;
reg [7:0] in_service_register;
reg [7:0] armed_reg;
reg [2:0] addr_low_reg;
reg level_trigger_select;
reg call_interval_select;
reg single_controller;
reg fourth_word_needed;
reg [7:0] init_word_two;
reg [7:0] init_word_three;
reg special_nesting_select;
reg buffered_reg;
reg role_reg;
reg automatic_end_of_service;
reg processor_mode_select;
reg special_mask_select;
reg read_isr_reg;
reg [1:0] ack_cnt_reg;
reg [2:0] ack_lvl_reg;
reg ack_found_reg;
reg ack_via_slave_reg;
reg ack_self_reg;

wire wr_done = wr_d_reg & ~wr_f;
wire rd_start = rd_f & ~rd_d_reg;
wire rd_end = rd_d_reg & ~rd_f;
wire ack_start = ack_f & ~ack_d_reg;
wire ack_end = ack_d_reg & ~ack_f;
wire ready = (state_reg == ST_READY);
wire cmd_write = wr_done & (wsel_reg == `PORT_SEL_COMMAND);
wire init_start = cmd_write & wdata_reg[`W1_MARK];
wire op2_write = ready & cmd_write & ~wdata_reg[`W1_MARK] & ~wdata_reg[`OP_KIND];
wire op3_write = ready & cmd_write & ~wdata_reg[`W1_MARK] & wdata_reg[`OP_KIND];
wire mask_write = ready & wr_done & (wsel_reg == `PORT_SEL_MASK);
wire is_master = buffered_reg ? role_reg : sp_f;
wire cascaded = ~single_controller;
wire [1:0] ack_last = processor_mode_select ? `ACK_LAST_16BIT : `ACK_LAST_8BIT;

// Lowest set index wins; bit 3 of the result flags an empty vector
function [3:0] pick;
  input [7:0] vec;
  integer k;
  begin
    pick = 4'h8;
    for (k = 7; k >= 0; k = k - 1) begin
      if (vec[k]) begin
        pick = {1'b0, k[2:0]};
      end
    end
  end
endfunction

// In special mask mode a masked in-service level stops blocking
wire [7:0] block_vec = special_mask_select ? (in_service_register & ~mask_register) : in_service_register;
wire [3:0] block_pick = pick(block_vec);
wire [3:0] req_pick = pick(request_register & ~mask_register);
wire req_ok = ~req_pick[3] & (req_pick < block_pick);

reg [7:0] isr_set;
reg [7:0] isr_clr;
reg [7:0] irr_clr;
reg eos_plain;

always @* begin
  isr_set = 8'h00;
  isr_clr = 8'h00;
  irr_clr = 8'h00;
  eos_plain = 1'b0;
  if (ready && ack_start && ack_cnt_reg == 2'h0 && req_ok) begin
    irr_clr[req_pick[2:0]] = 1'b1;
    if (is_master || !cascaded) begin
      isr_set[req_pick[2:0]] = 1'b1;
    end
  end
  // A slave only commits once the master has named it
  if (ready && ack_start && ack_cnt_reg == 2'h1 && !is_master && cascaded && ack_found_reg &&
      cas_f == init_word_three[2:0]) begin
    isr_set[ack_lvl_reg] = 1'b1;
  end
  if (ready && ack_end && ack_cnt_reg == ack_last && automatic_end_of_service) begin
    eos_plain = 1'b1;
  end
  if (op2_write && !wdata_reg[`OP2_ROTATE] && wdata_reg[`OP2_END]) begin
    if (wdata_reg[`OP2_SELECT_LEVEL]) begin
      isr_clr[wdata_reg[2:0]] = 1'b1;
    end else begin
      eos_plain = 1'b1;
    end
  end
  if (eos_plain && !block_pick[3]) begin
    isr_clr[block_pick[2:0]] = 1'b1;
  end
end

wire [7:0] irr_next;
wire [7:0] armed_next;

genvar gi;
generate
  for (gi = 0; gi < 8; gi = gi + 1) begin : g_req
    wire edge_hit = armed_reg[gi] & req_f[gi];
    // An input must be seen low before a rising level counts again
    assign armed_next[gi] = init_start ? 1'b0 : (~req_f[gi] | (armed_reg[gi] & ~edge_hit));
    assign irr_next[gi] = init_start ? 1'b0 :
                          level_trigger_select ? req_f[gi] :
                          (edge_hit | (request_register[gi] & ~irr_clr[gi] & req_f[gi]));
  end
endgenerate

always @* begin
  state_next = state_reg;
  if (init_start) begin
    state_next = ST_WAIT_W2;
  end else if (wr_done && wsel_reg == `PORT_SEL_MASK) begin
    case (state_reg)
      ST_WAIT_W2: state_next = single_controller ? (fourth_word_needed ? ST_WAIT_W4 : ST_READY) :
                               ST_WAIT_W3;
      ST_WAIT_W3: state_next = fourth_word_needed ? ST_WAIT_W4 : ST_READY;
      ST_WAIT_W4: state_next = ST_READY;
      default: state_next = state_reg;
    endcase
  end
end

always @(posedge i_mclk or negedge i_nrst) begin
  if (!i_nrst) begin
    state_reg <= ST_WAIT_W1;
    wr_d_reg <= 1'b0;
    rd_d_reg <= 1'b0;
    ack_d_reg <= 1'b0;
    wdata_reg <= 8'h00;
    wsel_reg <= 1'b0;
    mask_register <= `MASK_RESET;
    request_register <= 8'h00;
    in_service_register <= 8'h00;
    armed_reg <= 8'h00;
    addr_low_reg <= 3'h0;
    level_trigger_select <= 1'b0;
    call_interval_select <= 1'b0;
    single_controller <= 1'b0;
    fourth_word_needed <= 1'b0;
    init_word_two <= 8'h00;
    init_word_three <= {5'h00, `SLAVE_ID_RESET};
    special_nesting_select <= 1'b0;
    buffered_reg <= 1'b0;
    role_reg <= 1'b0;
    automatic_end_of_service <= 1'b0;
    processor_mode_select <= 1'b0;
    special_mask_select <= 1'b0;
    read_isr_reg <= 1'b0;
  end else if (i_ce) begin
    state_reg <= state_next;
    wr_d_reg <= wr_f;
    rd_d_reg <= rd_f;
    ack_d_reg <= ack_f;
    // Keep the last value seen under the strobe; it is acted on at the release
    if (wr_f) begin
      wdata_reg <= data_f;
      wsel_reg <= sel_f;
    end
    request_register <= irr_next;
    armed_reg <= armed_next;
    in_service_register <= (in_service_register & ~isr_clr) | isr_set; // Set wins over clear
    if (init_start) begin
      level_trigger_select <= wdata_reg[`W1_LEVEL_TRIG];
      call_interval_select <= wdata_reg[`W1_INTERVAL];
      single_controller <= wdata_reg[`W1_SINGLE];
      fourth_word_needed <= wdata_reg[`W1_FOURTH_NEEDED];
      addr_low_reg <= wdata_reg[`W1_ADDR_MSB:`W1_ADDR_LSB];
      mask_register <= `MASK_RESET;
      init_word_three <= {5'h00, `SLAVE_ID_RESET};
      special_mask_select <= 1'b0;
      read_isr_reg <= 1'b0;
      if (!wdata_reg[`W1_FOURTH_NEEDED]) begin
        special_nesting_select <= 1'b0;
        buffered_reg <= 1'b0;
        role_reg <= 1'b0;
        automatic_end_of_service <= 1'b0;
        processor_mode_select <= 1'b0;
      end
    end else if (wr_done && wsel_reg == `PORT_SEL_MASK) begin
      case (state_reg)
        ST_WAIT_W2: init_word_two <= wdata_reg;
        ST_WAIT_W3: init_word_three <= wdata_reg;
        ST_WAIT_W4: begin
          special_nesting_select <= wdata_reg[`W4_SPECIAL_NEST];
          buffered_reg <= wdata_reg[`W4_BUFFERED];
          role_reg <= wdata_reg[`W4_ROLE];
          automatic_end_of_service <= wdata_reg[`W4_AUTO_EOS];
          processor_mode_select <= wdata_reg[`W4_PROC_MODE];
        end
        ST_READY: mask_register <= wdata_reg;
        default: mask_register <= mask_register;
      endcase
    end
    if (op3_write) begin
      if (wdata_reg[`OP3_MASK_CHANGE]) begin
        special_mask_select <= wdata_reg[`OP3_MASK_SEL];
      end
      if (wdata_reg[`OP3_READ_REG]) begin
        read_isr_reg <= wdata_reg[`OP3_READ_SEL];
      end
    end
  end
end

// Acknowledge sequencing and the data, cascade and enable outputs
always @(posedge i_mclk or negedge i_nrst) begin
  if (!i_nrst) begin
    ack_cnt_reg <= 2'h0;
    ack_lvl_reg <= 3'h0;
    ack_found_reg <= 1'b0;
    ack_via_slave_reg <= 1'b0;
    ack_self_reg <= 1'b0;
    o_data <= 8'h00;
    o_data_oe <= 1'b0;
    o_int <= 1'b0;
    o_cascade_lines <= 3'h0;
    o_cascade_oe <= 1'b0;
    o_slave_program_or_buffer_enable <= 1'b1;
    o_slave_program_or_buffer_enable_oe <= 1'b0;
  end else if (i_ce) begin
    o_int <= ready & req_ok;
    o_cascade_oe <= ready & cascaded & is_master;
    o_slave_program_or_buffer_enable_oe <= buffered_reg;
    o_slave_program_or_buffer_enable <= ~(buffered_reg & o_data_oe);
    if (ready && ack_start) begin
      case (ack_cnt_reg)
        2'h0: begin
          ack_lvl_reg <= req_ok ? req_pick[2:0] : `DEFAULT_LEVEL;
          ack_found_reg <= req_ok;
          ack_via_slave_reg <= is_master & cascaded & init_word_three[req_ok ? req_pick[2:0] : `DEFAULT_LEVEL];
          if (is_master && cascaded) begin
            o_cascade_lines <= init_word_three[req_ok ? req_pick[2:0] : `DEFAULT_LEVEL] ?
                               (req_ok ? req_pick[2:0] : `DEFAULT_LEVEL) : 3'h0;
          end
          // In 8-bit mode the opening byte comes from the master or a lone controller; in 16-bit mode nothing drives the first pulse
          o_data <= `CALL_OPCODE;
          o_data_oe <= ~processor_mode_select & (is_master | ~cascaded);
          ack_cnt_reg <= 2'h1;
        end
        2'h1: begin
          ack_self_reg <= (is_master | ~cascaded) ? ~ack_via_slave_reg :
                          (cas_f == init_word_three[2:0]);
          if (processor_mode_select) begin
            o_data <= {init_word_two[7:3], ack_lvl_reg};
          end else if (call_interval_select) begin
            o_data <= {addr_low_reg, ack_lvl_reg, 2'h0};
          end else begin
            o_data <= {addr_low_reg[2:1], ack_lvl_reg, 3'h0};
          end
          o_data_oe <= (is_master | ~cascaded) ? ~ack_via_slave_reg :
                       (cas_f == init_word_three[2:0]);
          ack_cnt_reg <= 2'h2;
        end
        2'h2: begin
          o_data <= init_word_two;
          o_data_oe <= ack_self_reg & ~processor_mode_select;
          ack_cnt_reg <= 2'h3;
        end
        default: begin
          o_data_oe <= 1'b0;
          ack_cnt_reg <= 2'h0;
        end
      endcase
    end else if (ack_end) begin
      o_data_oe <= 1'b0;
      if (ack_cnt_reg == ack_last) begin
        ack_cnt_reg <= 2'h0;
        o_cascade_lines <= 3'h0;
      end
    end else if (rd_start && ack_cnt_reg == 2'h0) begin
      o_data <= (sel_f == `PORT_SEL_MASK) ? mask_register :
                (read_isr_reg ? in_service_register : request_register);
      o_data_oe <= 1'b1;
    end else if (rd_end) begin
      o_data_oe <= 1'b0;
    end
    if (init_start) begin
      ack_cnt_reg <= 2'h0;
      o_cascade_lines <= 3'h0;
    end
  end
end

endmodule // pic_cmd

/* File: tb/pic_cmd_chk.sv */
module pic_cmd_chk (
  input wire logic i_mclk, // clock
  input wire logic i_nrst, // reset
  input wire logic i_cs_n, // select
  input wire logic i_rd_n, // read
  input wire logic i_acknowledge_strobe_n, // ack
  input wire logic [7:0] i_request_inputs, // requests
  input wire logic i_slave_program_or_buffer_enable, // strap
  input wire logic o_data_oe, // data drive
  input wire logic o_int, // interrupt
  input wire logic [2:0] o_cascade_lines, // cascade
  input wire logic o_cascade_oe, // cascade drive
  input wire logic o_slave_program_or_buffer_enable, // buffer enable
  input wire logic o_slave_program_or_buffer_enable_oe // buffered
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  wire logic ack_n = i_acknowledge_strobe_n;
  wire logic bufen = o_slave_program_or_buffer_enable;
  wire logic buf_oe = o_slave_program_or_buffer_enable_oe;
  bufen_idle_a: assert property (!buf_oe |-> bufen)
    else $error("buffer enable low while unbuffered");
  bufen_follow_a: assert property (!bufen |-> $past(o_data_oe))
    else $error("buffer enable without data drive");
  bufen_drive_a: assert property (buf_oe && $rose(o_data_oe) |=> !bufen)
    else $error("buffer enable late");
  data_cause_a: assert property ($rose(o_data_oe) |-> $past(!ack_n || !(i_rd_n || i_cs_n), 2))
    else $error("data driven without read or acknowledge");
  data_release_a: assert property ((i_rd_n && ack_n) [*7] |-> !o_data_oe)
    else $error("data still driven after strobes ended");
  quiet_int_a: assert property ((i_request_inputs == 8'h00) [*8] |-> !o_int)
    else $error("interrupt with no request");
  reset_idle_a: assert property ($rose(i_nrst) |-> !o_int && !o_data_oe && !o_cascade_oe)
    else $error("outputs active after reset");
  casc_master_a: assert property (o_cascade_oe && !buf_oe |-> i_slave_program_or_buffer_enable)
    else $error("cascade driven by strapped slave");
  casc_hold_a: assert property (o_cascade_oe && $changed(o_cascade_lines) |-> $past(ack_n, 3) != $past(ack_n, 7))
    else $error("cascade lines moved outside acknowledge edge");
  cover property ($rose(o_int));
  cover property ($rose(o_data_oe) && !ack_n);
  cover property (o_cascade_oe && o_cascade_lines == 3'h2);
  cover property (buf_oe && !bufen);
endmodule // pic_cmd_chk

bind pic_cmd pic_cmd_chk chk (.*);

/* File: tb/host_model.sv */
module host_model (
  input wire logic i_mclk, // clock
  input wire logic [8:0] i_seen, // data drive and data
  output logic o_cs_n, // select
  output logic o_wr_n, // write
  output logic o_rd_n, // read
  output logic o_ack_n, // acknowledge
  output logic o_sel, // port select
  output logic [7:0] o_data // data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {o_cs_n, o_wr_n, o_rd_n, o_ack_n, o_sel} = 5'h1f;
    o_data = 8'h00;
  end
  // Strobes and data held 8 cycles, well past the synchroniser minimum
  task automatic cycle(input logic [2:0] kind, input logic sel, input logic [7:0] d, output logic [8:0] q);
    @(posedge i_mclk);
    o_sel <= sel;
    o_data <= d;
    o_cs_n <= kind[2];
    o_rd_n <= !kind[1];
    o_wr_n <= !kind[0];
    o_ack_n <= !kind[2];
    repeat (8) @(posedge i_mclk);
    q = i_seen;
    {o_cs_n, o_wr_n, o_rd_n, o_ack_n} <= 4'hf;
    repeat (8) @(posedge i_mclk);
    o_data <= ~d; // Released bus must not keep showing the old byte
  endtask
endmodule // host_model

/* File: tb/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic [7:0] req = 8'h00;
  logic cs_n, wr_n, rd_n, ack_n, sel, data_oe, irq, casc_oe;
  logic [7:0] hdata, data_out;
  logic [2:0] casc;
  logic [2:0] casc_in = 3'h0;
  logic buf_oe;
  logic [8:0] q;
  int err_total = 0;
  int num_checks = 0;
  pic_cmd dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(1'b1), .i_cs_n(cs_n), .i_wr_n(wr_n), .i_rd_n(rd_n),
    .i_port_select_line(sel), .i_data(hdata), .o_data(data_out), .o_data_oe(data_oe), .i_request_inputs(req),
    .i_acknowledge_strobe_n(ack_n), .o_int(irq), .i_cascade_lines(casc_in), .o_cascade_lines(casc),
    .o_cascade_oe(casc_oe), .i_slave_program_or_buffer_enable(1'b1), .o_slave_program_or_buffer_enable(),
    .o_slave_program_or_buffer_enable_oe(buf_oe));
  host_model hm (.i_mclk(i_mclk), .i_seen({data_oe, data_out}), .o_cs_n(cs_n), .o_wr_n(wr_n), .o_rd_n(rd_n),
    .o_ack_n(ack_n), .o_sel(sel), .o_data(hdata));
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic w(input logic s, input logic [7:0] d);
    hm.cycle(3'b001, s, d, q);
  endtask
  task automatic r(input logic s);
    hm.cycle(3'b010, s, 8'h00, q);
  endtask
  task automatic a();
    hm.cycle(3'b100, 1'b0, 8'h00, q);
  endtask
  task automatic req_set(input logic [7:0] v);
    @(posedge i_mclk);
    req <= v;
    repeat (10) @(posedge i_mclk);
  endtask
  task automatic t_single8();
    req_set(8'h00);
    w(0, 8'hb6);
    w(1, 8'h20);
    w(1, 8'hf0);
    r(1);
    check(q, 9'h1f0);
    req_set(8'h04);
    check({8'h00, irq}, 9'h001);
    a();
    check(q, 9'h1cd);
    a();
    check(q, 9'h1a8);
    a();
    check(q, 9'h120);
    w(0, 8'h0b);
    r(0);
    check(q, 9'h104);
    req_set(8'h0c);
    check({8'h00, irq}, 9'h000);
    req_set(8'h0e);
    check({8'h00, irq}, 9'h001);
    a();
    a();
    check(q, 9'h1a4);
    a();
    w(0, 8'h20);
    r(0);
    check(q, 9'h104);
    w(0, 8'h62);
    r(0);
    check(q, 9'h100);
  endtask
  task automatic t_auto16();
    req_set(8'h00);
    w(0, 8'h13);
    w(1, 8'h48);
    w(1, 8'h03);
    r(1);
    check(q, 9'h100);
    req_set(8'h20);
    r(0);
    check(q, 9'h120);
    a();
    check({8'h00, q[8]}, 9'h000);
    a();
    check(q, 9'h14d);
    w(0, 8'h0b);
    r(0);
    check(q, 9'h100);
    a();
    a();
    check(q, 9'h14f);
    r(0);
    check(q, 9'h100);
  endtask
  task automatic t_level();
    w(0, 8'h1a);
    w(1, 8'h00);
    check({8'h00, irq}, 9'h001);
    a();
    a();
    check(q, 9'h128);
    a();
    w(1, 8'h20);
    req_set(8'h60);
    check({8'h00, irq}, 9'h000);
    w(0, 8'h68);
    check({8'h00, irq}, 9'h001);
    w(0, 8'h28);
    check({8'h00, irq}, 9'h001);
    w(0, 8'h20);
    w(0, 8'h48);
    check({8'h00, irq}, 9'h000);
  endtask
  task automatic t_cascade();
    req_set(8'h00);
    w(0, 8'h11);
    w(1, 8'h00);
    w(1, 8'h04);
    w(1, 8'h00);
    check({8'h00, casc_oe}, 9'h001);
    req_set(8'h04);
    a();
    check(q, 9'h1cd);
    check({6'h00, casc}, 9'h002);
    a();
    check({8'h00, q[8]}, 9'h000);
    a();
    w(0, 8'h20);
    w(0, 8'h0b);
    r(0);
    check(q, 9'h120);
  endtask
  // Buffered slave: the role bit wins over the master strap
  task automatic t_slave();
    w(0, 8'h11);
    w(1, 8'h90);
    w(1, 8'h03);
    w(1, 8'h08);
    check({7'h00, casc_oe, buf_oe}, 9'h001);
    casc_in <= 3'h3;
    req_set(8'h02);
    check({8'h00, irq}, 9'h001);
    a();
    check({8'h00, q[8]}, 9'h000);
    a();
    check(q, 9'h108);
    a();
    check(q, 9'h190);
    w(0, 8'h0b);
    r(0);
    check(q, 9'h122);
    w(0, 8'h20);
    r(0);
    check(q, 9'h120);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    forever #12.5 i_mclk = ~i_mclk;
  end
  initial begin
    repeat (5) @(posedge i_mclk);
    i_nrst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    t_single8();
    t_auto16();
    t_level();
    t_cascade();
    t_slave();
    wrap_up();
  end
  // About 1120 cycles are needed; a hang is cut off well beyond that
  initial begin
    repeat (6000) @(posedge i_mclk);
    err_total++;
    wrap_up();
  end
endmodule // testbench
